// File: bench/qlhcp_host.sv
`timescale 1ns/10ps
module qlhcp_host (
    output logic serial_clock,
    output logic [3:0] chip_select_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic output_edge_select
);
    logic [7:0] tx [26];
    logic [7:0] rx [26];
    logic en [26];
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
        // The selects settle after time zero, so the idle clear of the link logic sees a real edge.
        #1 chip_select_n = 4'hf;
    end
    task automatic grab(input int k, input int i);
        rx[k][i] = serial_out;
        en[k] = serial_out_en;
    endtask
    // The clock runs only inside a frame, so the device must not lean on free-running edges.
    task automatic frame(input logic [3:0] cs, input int n, input int part);
        chip_select_n = cs;
        #20;
        for (int k = 0; k <= n; k++) begin
            rx[k] = 8'h00;
            en[k] = 1'b0;
            for (int i = 0; i < 8 && (k < n || i < part); i++) begin
                serial_in = tx[k][i];
                #7 serial_clock = 1'b1;
                if (!output_edge_select) grab(k, i);
                #15 serial_clock = 1'b0;
                if (output_edge_select) grab(k, i);
                #8;
            end
        end
        serial_in = ~serial_in;
        #40 chip_select_n = 4'hf;
        #60;
    endtask
endmodule

// File: bench/qlhcp_sva.sv
`timescale 1ns/10ps
module qlhcp_sva
    import qlhcp_pkg::*;
#(
    parameter int NUM_CH = CHANNELS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic [NUM_CH-1:0] chip_select_n,
    input wire logic bus_iface_select_hi,
    input wire logic bus_iface_select_lo,
    input wire logic bus_timing_style,
    input wire logic hard_reset_n,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic serial_mode,
    input wire logic hardware_mode,
    input wire logic parallel_mode,
    input wire logic parallel_muxed,
    input wire logic parallel_style,
    input wire logic [NUM_CH-1:0] interface_reset_bit
);
    logic hi, lo, idle;
    assign hi = bus_iface_select_hi;
    assign lo = bus_iface_select_lo;
    assign idle = &chip_select_n;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_ser;
        (hi && !lo) [*5] |=> serial_mode && !hardware_mode && !parallel_mode;
    endproperty
    a_ser: assert property (p_ser) else $error("serial mode not decoded");
    property p_hw;
        (hi && lo) [*5] |=> hardware_mode && !serial_mode && !parallel_mode;
    endproperty
    a_hw: assert property (p_hw) else $error("hardware mode not decoded");
    property p_mux;
        (!hi && !lo && bus_timing_style) [*5] |=> parallel_mode && parallel_muxed && parallel_style;
    endproperty
    a_mux: assert property (p_mux) else $error("muxed parallel mode wrong");
    property p_sep;
        (!hi && lo && !bus_timing_style) [*5] |=> parallel_mode && !parallel_muxed && !parallel_style;
    endproperty
    a_sep: assert property (p_sep) else $error("separate parallel mode wrong");
    property p_idle;
        idle |-> !serial_out_en;
    endproperty
    a_idle: assert property (p_idle) else $error("serial out driven while idle");
    property p_port;
        !serial_mode |-> !serial_out_en;
    endproperty
    a_port: assert property (p_port) else $error("serial out driven outside serial mode");
    property p_edge;
        $stable(serial_clock) && !idle && !$past(idle) |-> $stable(serial_out) && $stable(serial_out_en);
    endproperty
    a_edge: assert property (p_edge) else $error("serial out moved without a clock edge");
    property p_hard;
        !hard_reset_n [*4] |=> interface_reset_bit == '0;
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset did not clear");
    property p_por;
        $rose(rst_n) |-> !serial_mode && !hardware_mode && !parallel_mode && interface_reset_bit == '0;
    endproperty
    a_por: assert property (p_por) else $error("outputs not cleared by reset");
endmodule
bind qlhcp_top qlhcp_sva #(.NUM_CH(NUM_CH)) i_sva (.clock, .rst_n, .serial_clock, .chip_select_n,
    .bus_iface_select_hi, .bus_iface_select_lo, .bus_timing_style, .hard_reset_n, .serial_out,
    .serial_out_en, .serial_mode, .hardware_mode, .parallel_mode, .parallel_muxed, .parallel_style,
    .interface_reset_bit);

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import qlhcp_pkg::*;
    logic clock = 1'b1;
    logic rst_n = 1'b1;
    logic hi = 1'b1;
    logic lo = 1'b0;
    logic bts = 1'b0;
    logic input_edge_select = 1'b0;
    logic output_edge_select = 1'b0;
    logic hard_n = 1'b1;
    logic sclk, sin, sout, soe, line, smode, hmode, pmode, pmux, pstyle;
    logic [3:0] cs_n, irb;
    int bad_count = 0;
    int checks = 0;
    always #2 clock = ~clock;
    // Nothing pulls the line, so a floating output must never read as data.
    assign line = soe ? sout : 1'bz;
    qlhcp_top i_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .serial_clock(sclk), .chip_select_n(cs_n),
        .serial_in(sin), .bus_iface_select_hi(hi), .bus_iface_select_lo(lo),
        .input_edge_select(input_edge_select), .output_edge_select(output_edge_select),
        .bus_timing_style(bts), .hard_reset_n(hard_n), .serial_out(sout),
        .serial_out_en(soe), .serial_mode(smode), .hardware_mode(hmode), .parallel_mode(pmode),
        .parallel_muxed(pmux), .parallel_style(pstyle), .interface_reset_bit(irb));
    qlhcp_host i_host (.serial_clock(sclk), .chip_select_n(cs_n), .serial_in(sin), .serial_out(line),
        .serial_out_en(soe), .output_edge_select(output_edge_select));
    ////////////////////////////////////////////////////////////
    function automatic logic [3:0] sel(input int ch);
        return ~(4'h1 << ch);
    endfunction
    function automatic logic [7:0] bval(input int k);
        return 8'(k * 7 + 1);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] cs, input logic [4:0] a, input logic [7:0] d);
        i_host.tx[0] = {2'b10, a, 1'b0};
        i_host.tx[1] = d;
        i_host.frame(cs, 2, 0);
    endtask
    task automatic rd(input int ch, input logic [4:0] a, input logic [7:0] exp);
        i_host.tx[0] = {2'b10, a, 1'b1};
        i_host.tx[1] = 8'h96;
        i_host.frame(sel(ch), 2, 0);
        check(i_host.rx[1], exp);
        check({7'h0, i_host.en[1]}, 8'h01);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_std;
        rd(1, 5'h03, REG_RESET);
        for (int c = 0; c < 4; c++) wr(sel(c), 5'h07, 8'h30 + 8'(c));
        for (int c = 0; c < 4; c++) rd(c, 5'h07, 8'h30 + 8'(c));
        $display("t_std done");
    endtask
    task automatic t_modes;
        for (int v = 0; v < 8; v++) begin
            @(negedge clock);
            {hi, lo, bts} = 3'(v);
            repeat (6) @(negedge clock);
            check({3'h0, smode, hmode, pmode, pmux, pstyle},
                  {3'h0, hi & ~lo, hi & lo, ~hi, ~hi & ~lo, ~hi & bts});
        end
        wr(sel(0), 5'h07, 8'hff);
        @(negedge clock);
        {hi, lo, bts} = 3'b100;
        repeat (6) @(negedge clock);
        rd(0, 5'h07, 8'h30);
        $display("t_modes done");
    endtask
    task automatic t_bcast;
        wr(4'b1010, COMMON_CONTROL_THREE_ADDR, 8'h04);
        check({4'h0, irb}, 8'h05);
        rd(1, COMMON_CONTROL_THREE_ADDR, REG_RESET);
        wr(4'b1010, COMMON_CONTROL_THREE_ADDR, 8'h00);
        check({4'h0, irb}, 8'h00);
        $display("t_bcast done");
    endtask
    task automatic t_refuse;
        wr(sel(0), STATUS_ADDR, 8'h5a);
        rd(0, STATUS_ADDR, REG_RESET);
        wr(sel(0), 5'h16, 8'ha5);
        rd(0, 5'h16, REG_RESET);
        $display("t_refuse done");
    endtask
    task automatic t_abort;
        i_host.tx[0] = {2'b10, 5'h07, 1'b0};
        i_host.tx[1] = 8'hff;
        i_host.frame(sel(1), 1, 4);
        rd(1, 5'h07, 8'h31);
        i_host.tx[0][0] = 1'b1;
        i_host.frame(sel(1), 1, 3);
        check({7'h0, soe}, 8'h00);
        $display("t_abort done");
    endtask
    task automatic t_edges;
        for (int j = 0; j < 2; j++) begin
            @(negedge clock);
            {input_edge_select, output_edge_select} = j ? 2'b11 : 2'b01;
            repeat (4) @(negedge clock);
            wr(sel(2), 5'h0a, 8'hc0 + 8'(j));
            rd(2, 5'h0a, 8'hc0 + 8'(j));
        end
        @(negedge clock);
        {input_edge_select, output_edge_select} = 2'b00;
        // Let the straps settle before the next frame so the derived link clocks do not glitch mid-frame.
        repeat (4) @(negedge clock);
        $display("t_edges done");
    endtask
    task automatic t_burst;
        logic [7:0] exp;
        i_host.tx[0] = 8'h00;
        for (int k = 1; k <= 24; k++) i_host.tx[k] = bval(k - 1);
        i_host.frame(sel(3), 25, 0);
        i_host.tx[0] = 8'h01;
        i_host.frame(sel(3), 24, 0);
        for (int k = 0; k < REG_COUNT; k++) begin
            exp = 5'(k) inside {STATUS_ADDR, RX_INFO1_ADDR, RX_INFO2_ADDR, ERR_CNT1_ADDR, ERR_CNT2_ADDR}
                ? REG_RESET : bval(k);
            check(i_host.rx[k + 1], exp);
        end
        check({7'h0, i_host.en[23]}, 8'h00);
        rd(3, LAST_ADDR, bval(REG_COUNT - 1));
        $display("t_burst done");
    endtask
    task automatic t_hard;
        @(negedge clock);
        hard_n = 1'b0;
        repeat (6) @(negedge clock);
        check({4'h0, irb}, 8'h00);
        hard_n = 1'b1;
        repeat (6) @(negedge clock);
        rd(3, 5'h07, REG_RESET);
        $display("t_hard done");
    endtask
    initial begin
        // Reset falls after time zero so the asynchronously cleared link holders see a real edge.
        @(negedge clock);
        rst_n = 1'b0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        t_std;
        t_modes;
        t_bcast;
        t_refuse;
        t_abort;
        t_edges;
        t_burst;
        t_hard;
        print_verdict;
    end
    initial begin
        #300000;
        bad_count++;
        print_verdict;
    end
endmodule

// File: common/qlhcp_pkg.sv
package qlhcp_pkg;
    // Channel count and register map shape.
    localparam int CHANNELS = 4;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 22;
    localparam logic [4:0] FIRST_ADDR = 5'h00;
    localparam logic [4:0] LAST_ADDR = 5'h15;

    // Command byte field positions, bit 0 shifted first.
    localparam int CMD_DIR_BIT = 0;
    localparam int CMD_ADDR_LSB = 1;
    localparam int CMD_ADDR_MSB = 5;
    localparam int CMD_RSVD_BIT = 6;
    localparam int CMD_BURST_BIT = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] PREFETCH_BIT = 3'h2;

    // Register contents after reset.
    localparam logic [7:0] REG_RESET = 8'h00;

    // Read-only status and information registers; writes to them are dropped.
    localparam logic [4:0] STATUS_ADDR = 5'h06;
    localparam logic [4:0] RX_INFO1_ADDR = 5'h08;
    localparam logic [4:0] RX_INFO2_ADDR = 5'h09;
    localparam logic [4:0] ERR_CNT1_ADDR = 5'h11;
    localparam logic [4:0] ERR_CNT2_ADDR = 5'h12;

    // Interface reset control.
    localparam logic [4:0] COMMON_CONTROL_THREE_ADDR = 5'h02;
    localparam int INTERFACE_RESET_POS = 2;

    typedef enum logic [1:0] {
        QLHCP_CMD,
        QLHCP_DATA,
        QLHCP_DONE
    } qlhcp_phase_type;
endpackage

// File: hw/qlhcp_regfile.sv
`timescale 1ns/10ps
module qlhcp_regfile
    import qlhcp_pkg::*;
#(
    parameter int NUM_CH = CHANNELS,
    parameter int DEPTH = REG_COUNT
) (
    input wire logic clock,
    input wire logic clear_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [NUM_CH-1:0] wr_mask,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [1:0] rd_ch,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    output logic [NUM_CH-1:0] iface_reset
);
    logic [DATA_W-1:0] regs [NUM_CH][DEPTH];
    logic wr_ok;

    assign wr_ok = wr_en && (wr_addr <= LAST_ADDR) && (wr_addr != STATUS_ADDR)
        && (wr_addr != RX_INFO1_ADDR) && (wr_addr != RX_INFO2_ADDR)
        && (wr_addr != ERR_CNT1_ADDR) && (wr_addr != ERR_CNT2_ADDR);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            // Each channel owns a full copy of the map.
            always_ff @(posedge clock) begin
                if (!clear_n) begin
                    for (int r = 0; r < DEPTH; r++) begin
                        regs[ch][r] <= REG_RESET; // [RL21] [RL22]
                    end
                end else if (ce && wr_ok && wr_mask[ch]) begin
                    regs[ch][wr_addr] <= wr_data; // [RL18] [RL20]
                end
            end
            assign iface_reset[ch] = regs[ch][COMMON_CONTROL_THREE_ADDR][INTERFACE_RESET_POS];
        end
    endgenerate

    // Out-of-range addresses read as zero.
    always_comb begin
        rd_data = REG_RESET;
        if (rd_addr <= LAST_ADDR) begin
            rd_data = regs[rd_ch][rd_addr];
        end
    end
endmodule

// File: hw/qlhcp_sync.sv
`timescale 1ns/10ps
module qlhcp_sync
    import qlhcp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage_one <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

// File: hw/qlhcp_top.sv
`timescale 1ns/10ps
// Function
// (RL1) Serial port is enabled when the upper select is high and the lower is low.
// (RL2) Both selects high: hardware pin mode, no register port in use.
// (RL3) Serial accesses run only on the serial clock, asynchronous to line timing.
// (RL4) Command and data bytes shift least significant bit first both ways.
// (RL5) Input edge select low samples on rising edge, high on falling edge.
// (RL6) Output edge select low changes data on falling edge, high on rising.
// (RL7) Host opens a transfer with chip select low and releases it between transfers.
// (RL8) A channel's transfer aborts as soon as its chip select goes high.
// (RL9) With all chip selects inactive the port idles and serial out floats.
// (RL10) Standard access is one command byte then one data byte.
// (RL11) Burst access is one command byte then 22 data bytes, same direction.
// (RL12) First command bit gives direction: one reads, zero writes.
// (RL13) Next five command bits are the address; only 00h to 15h are valid.
// (RL14) Host sends the reserved seventh command bit as zero.
// (RL15) Last command bit zero means burst, walking registers upward from 00h.
// (RL16) A burst stops after register 15h or when chip select goes inactive.
// (RL17) Host sends zero address bits in a burst command.
// (RL18) Writes go to every selected channel; reads need a single selected channel.
// (RL19) Parallel mode: lower select picks muxed bus, timing pin picks bus style.
// (RL20) Each channel has its own identical register map behind its chip select.
// (RL21) Power-up reset loads 00h into all registers and clears status.
// (RL22) Holding the hard reset input low restores defaults, level sensitive.
// (RL23) Host programs controls, then toggles the interface reset bit in register 02h.
// (RL24) Burst write bytes after register 15h are ignored until chip select release.
module qlhcp_top
    import qlhcp_pkg::*;
#(
    parameter int NUM_CH = CHANNELS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic serial_clock,
    input wire logic [NUM_CH-1:0] chip_select_n,
    input wire logic serial_in,
    input wire logic bus_iface_select_hi,
    input wire logic bus_iface_select_lo,
    input wire logic input_edge_select,
    input wire logic output_edge_select,
    input wire logic bus_timing_style,
    input wire logic hard_reset_n,
    output logic serial_out,
    output logic serial_out_en,
    output logic serial_mode,
    output logic hardware_mode,
    output logic parallel_mode,
    output logic parallel_muxed,
    output logic parallel_style,
    output logic [NUM_CH-1:0] interface_reset_bit
);
    ////////////////////////////////////////////////////////////////////////////
    // System clock domain: pin synchronisers and mode decode.
    logic [7:0] pins_sync;
    logic sel_hi;
    logic sel_lo;
    logic in_edge_s;
    logic out_edge_s;
    logic style_s;
    logic hard_reset_s_n;
    logic wr_tgl_s;
    logic rd_tgl_s;
    logic in_edge;
    logic out_edge;
    logic wr_seen;
    logic rd_seen;
    logic wr_event;
    logic rd_event;
    logic clear_n;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] rd_hold;
    logic [NUM_CH-1:0] iface_reset;

    // Link-domain holding registers, stable while their toggle is in flight.
    logic wr_tgl;
    logic rd_tgl;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [NUM_CH-1:0] wr_mask;
    logic [ADDR_W-1:0] rd_addr;
    logic [1:0] rd_ch;

    qlhcp_sync #(
        .WIDTH(8)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({bus_iface_select_hi, bus_iface_select_lo, input_edge_select, output_edge_select,
                   bus_timing_style, hard_reset_n, wr_tgl, rd_tgl}),
        .sync_out(pins_sync)
    );

    assign {sel_hi, sel_lo, in_edge_s, out_edge_s, style_s, hard_reset_s_n, wr_tgl_s, rd_tgl_s} = pins_sync;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serial_mode <= 1'b0;
            hardware_mode <= 1'b0;
            parallel_mode <= 1'b0;
            parallel_muxed <= 1'b0;
            parallel_style <= 1'b0;
        end else if (ce) begin
            serial_mode <= sel_hi && !sel_lo; // [RL1]
            hardware_mode <= sel_hi && sel_lo; // [RL2]
            parallel_mode <= !sel_hi;
            parallel_muxed <= !sel_hi && !sel_lo; // [RL19]
            parallel_style <= !sel_hi && style_s; // [RL19]
        end
    end

    // Edge selects are straps; changing them mid-transfer glitches the link clocks.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_edge <= 1'b0;
            out_edge <= 1'b0;
        end else if (ce) begin
            in_edge <= in_edge_s;
            out_edge <= out_edge_s;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_seen <= 1'b0;
            rd_seen <= 1'b0;
        end else if (ce) begin
            wr_seen <= wr_tgl_s;
            rd_seen <= rd_tgl_s;
        end
    end

    // Serial writes only land while the serial port is selected.
    assign wr_event = (wr_tgl_s != wr_seen) && serial_mode; // [RL1] [RL2]
    assign rd_event = rd_tgl_s != rd_seen;
    assign clear_n = rst_n && hard_reset_s_n; // [RL21] [RL22]

    qlhcp_regfile #(
        .NUM_CH(NUM_CH),
        .DEPTH(REG_COUNT)
    ) u_regfile (
        .clock(clock),
        .clear_n(clear_n),
        .ce(ce),
        .wr_en(wr_event),
        .wr_mask(wr_mask),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_ch(rd_ch),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .iface_reset(iface_reset)
    );

    // Read data is fetched ahead of use so the link side sees it settled.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_hold <= REG_RESET;
        end else if (ce && rd_event) begin
            rd_hold <= rd_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            interface_reset_bit <= '0;
        end else if (ce) begin
            interface_reset_bit <= iface_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock domain. Both link clocks derive from the serial clock and the registered edge selects.
    logic sample_clk;
    logic out_clk;
    logic link_clr_n;
    qlhcp_phase_type phase;
    logic [2:0] bit_cnt;
    logic [6:0] byte_q;
    logic is_read;
    logic is_burst;
    logic [ADDR_W-1:0] addr;
    logic [NUM_CH-1:0] chan_live;
    logic [NUM_CH-1:0] next_live;
    logic [DATA_W-1:0] next_byte;
    logic [1:0] next_rd_ch;
    logic last_bit;
    logic take_write;
    logic cmd_read_req;
    logic burst_read_req;

    assign sample_clk = serial_clock ^ in_edge; // [RL3] [RL5]
    assign out_clk = serial_clock ^ !out_edge; // [RL6]
    // Idle whenever no channel is selected or the serial port is not chosen.
    assign link_clr_n = !(&chip_select_n) && serial_mode; // [RL9]

    assign last_bit = bit_cnt == LAST_BIT;
    assign next_byte = {serial_in, byte_q}; // [RL4]
    // A channel drops out of the transfer once its select rises.
    assign next_live = ((phase == QLHCP_CMD) && (bit_cnt == 3'h0)) ? ~chip_select_n
                     : (chan_live & ~chip_select_n); // [RL8]

    always_comb begin
        next_rd_ch = 2'h0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (next_live[c]) begin
                next_rd_ch = 2'(c);
            end
        end
    end

    always_ff @(posedge sample_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            phase <= QLHCP_CMD;
            bit_cnt <= 3'h0;
            byte_q <= 7'h00;
            is_read <= 1'b0;
            is_burst <= 1'b0;
            addr <= FIRST_ADDR;
            chan_live <= '0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            chan_live <= next_live;
            if (!last_bit) begin
                byte_q[bit_cnt] <= serial_in; // [RL4]
            end
            unique case (phase)
                QLHCP_CMD: begin
                    if (last_bit) begin
                        is_read <= byte_q[CMD_DIR_BIT]; // [RL12]
                        is_burst <= !serial_in; // [RL15]
                        addr <= serial_in ? byte_q[CMD_ADDR_MSB:CMD_ADDR_LSB] : FIRST_ADDR; // [RL13] [RL15]
                        phase <= QLHCP_DATA;
                    end
                end
                QLHCP_DATA: begin
                    if (last_bit) begin
                        if (is_burst && addr != LAST_ADDR) begin
                            addr <= addr + 5'h01; // [RL11] [RL15]
                        end else begin
                            phase <= QLHCP_DONE; // [RL10] [RL16] [RL24]
                        end
                    end
                end
                QLHCP_DONE: begin
                    phase <= QLHCP_DONE;
                end
            endcase
        end
    end

    assign take_write = (phase == QLHCP_DATA) && last_bit && !is_read && (addr <= LAST_ADDR); // [RL13]
    assign cmd_read_req = (phase == QLHCP_CMD) && (bit_cnt == 3'h5) && byte_q[CMD_DIR_BIT];
    assign burst_read_req = (phase == QLHCP_DATA) && (bit_cnt == PREFETCH_BIT) && is_read && is_burst
        && (addr != LAST_ADDR);

    // These survive chip select release, so a cleared frame cannot fake a toggle.
    always_ff @(posedge sample_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_tgl <= 1'b0;
            wr_addr <= FIRST_ADDR;
            wr_data <= REG_RESET;
            wr_mask <= '0;
        end else if (link_clr_n && take_write) begin
            wr_tgl <= !wr_tgl;
            wr_addr <= addr;
            wr_data <= next_byte;
            wr_mask <= next_live; // [RL8] [RL18]
        end
    end

    always_ff @(posedge sample_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_tgl <= 1'b0;
            rd_addr <= FIRST_ADDR;
            rd_ch <= 2'h0;
        end else if (link_clr_n && (cmd_read_req || burst_read_req)) begin
            rd_tgl <= !rd_tgl;
            rd_addr <= burst_read_req ? addr + 5'h01 : {serial_in, byte_q[4:1]}; // [RL15]
            rd_ch <= next_rd_ch; // [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output shifter on the selected output edge.
    logic [DATA_W-1:0] tx_shift;
    logic [2:0] tx_cnt;
    logic tx_on;
    logic tx_busy;

    assign tx_busy = tx_on && (tx_cnt != LAST_BIT);

    always_ff @(posedge out_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            tx_shift <= REG_RESET;
            tx_cnt <= 3'h0;
            tx_on <= 1'b0;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0; // [RL9]
        end else if (tx_busy) begin
            serial_out <= tx_shift[0]; // [RL4] [RL6]
            tx_shift <= tx_shift >> 1;
            tx_cnt <= tx_cnt + 3'h1;
        end else if ((phase == QLHCP_DATA) && is_read) begin
            serial_out <= rd_hold[0]; // [RL10]
            tx_shift <= rd_hold >> 1;
            tx_cnt <= 3'h0;
            tx_on <= 1'b1;
            serial_out_en <= 1'b1;
        end else begin
            tx_on <= 1'b0;
            serial_out_en <= 1'b0; // [RL16]
        end
    end
endmodule
